// ### hw/svc_pkg.sv
// Package with offsets, field positions and reset values of the configuration slice.
package svc_pkg;
  // ****************************************************************
  // Bus geometry
  // ****************************************************************
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned NUM_REGS = 8;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [7:0] FIXED_PATTERN_13_OFS = 8'h0d;
  localparam logic [7:0] PUMP_GAIN_CONTROL_OFS = 8'h0e;
  localparam logic [7:0] FIXED_PATTERN_15_OFS = 8'h0f;
  localparam logic [7:0] OSC_CURRENT_OVERRIDE_OFS = 8'h10;
  localparam logic [7:0] OSC_CURRENT_CAL_START_OFS = 8'h11;
  localparam logic [7:0] FIXED_PATTERN_18_OFS = 8'h12;
  localparam logic [7:0] OSC_BAND_OVERRIDE_OFS = 8'h13;
  localparam logic [7:0] CORE_SELECT_CONTROL_OFS = 8'h14;
  // Lowest offset of the slice; register index is offset minus this base.
  localparam logic [7:0] SLICE_BASE_OFS = FIXED_PATTERN_13_OFS;

  // Array indices of the registers that carry fields.
  localparam int unsigned IDX_PUMP = 1;
  localparam int unsigned IDX_BIAS = 3;
  localparam int unsigned IDX_START = 4;
  localparam int unsigned IDX_BAND = 6;
  localparam int unsigned IDX_CORE = 7;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [15:0] FIXED_PATTERN_13_RST = 16'h4000;
  localparam logic [15:0] PUMP_GAIN_CONTROL_RST = 16'h1840;
  localparam logic [15:0] FIXED_PATTERN_15_RST = 16'h060e;
  localparam logic [15:0] OSC_CURRENT_OVERRIDE_RST = 16'h0080;
  localparam logic [15:0] OSC_CURRENT_CAL_START_RST = 16'h0096;
  localparam logic [15:0] FIXED_PATTERN_18_RST = 16'h0064;
  localparam logic [15:0] OSC_BAND_OVERRIDE_RST = 16'h27b7;
  localparam logic [15:0] CORE_SELECT_CONTROL_RST = 16'h3048;
  localparam logic [NUM_REGS*16-1:0] RESET_TABLE = {
    CORE_SELECT_CONTROL_RST, OSC_BAND_OVERRIDE_RST, FIXED_PATTERN_18_RST,
    OSC_CURRENT_CAL_START_RST, OSC_CURRENT_OVERRIDE_RST, FIXED_PATTERN_15_RST,
    PUMP_GAIN_CONTROL_RST, FIXED_PATTERN_13_RST};

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int unsigned PUMP_GAIN_LSB = 3;
  localparam int unsigned PUMP_GAIN_W = 4;
  localparam int unsigned BIAS_W = 9;
  localparam int unsigned BAND_W = 8;
  localparam int unsigned CORE_SEL_LSB = 11;
  localparam int unsigned CORE_SEL_W = 3;
  localparam int unsigned CORE_OVR_BIT = 10;

  // ****************************************************************
  // Field code limits
  // ****************************************************************
  localparam logic [3:0] PUMP_GAIN_TRISTATE = 4'h0;
  localparam logic [7:0] BAND_CODE_MAX = 8'hb7;
  localparam logic [2:0] CORE_CODE_MIN = 3'h1;
  localparam logic [2:0] CORE_CODE_MAX = 3'h6;
endpackage

// ### hw/svc_ovr_if.sv
// Interface joining the register bank to its override selector.
`timescale 1ns/1ps
`default_nettype none
interface svc_ovr_if;
  logic [8:0] bias_cal;
  logic [8:0] bias_man;
  logic bias_force;
  logic [8:0] bias_sel;
  logic [7:0] band_cal;
  logic [7:0] band_man;
  logic band_force;
  logic [7:0] band_sel;
  logic [2:0] core_cal;
  logic [2:0] core_man;
  logic core_force;
  logic [2:0] core_sel;

  // The bank supplies both candidates and the enables.
  modport bank (
    output bias_cal, bias_man, bias_force, band_cal, band_man, band_force,
    output core_cal, core_man, core_force,
    input bias_sel, band_sel, core_sel
  );
  // The selector returns the chosen values.
  modport sel (
    input bias_cal, bias_man, bias_force, band_cal, band_man, band_force,
    input core_cal, core_man, core_force,
    output bias_sel, band_sel, core_sel
  );
endinterface
`default_nettype wire

// ### hw/svc_override_mux.sv
// Selector between calibration results and programmed override values.
`timescale 1ns/1ps
`default_nettype none
module svc_override_mux (
  // Candidates in, chosen values out
  svc_ovr_if.sel ovr
);
  // ****************************************************************
  // Selection
  // ****************************************************************
  // Clear enable keeps the calibration result, set enable takes the register value (for the core only a code from 1 to 6).
  always_comb begin
    ovr.bias_sel = ovr.bias_force ? ovr.bias_man : ovr.bias_cal;
    ovr.band_sel = ovr.band_force ? ovr.band_man : ovr.band_cal;
    // An unused core code would name no core, so it falls back to calibration.
    if (ovr.core_force && ovr.core_man >= svc_pkg::CORE_CODE_MIN &&
        ovr.core_man <= svc_pkg::CORE_CODE_MAX) begin
      ovr.core_sel = ovr.core_man;
    end else begin
      ovr.core_sel = ovr.core_cal;
    end
  end
endmodule
`default_nettype wire

// ### hw/svc_config_regs.sv
// Top of the synthesizer configuration slice, offsets 0x0d to 0x14.
// Soft reset reloads all eight registers, not only the three fixed-pattern ones,
// so a host that relies on defaults after a reset finds every field at its reset value.
// The bias and band override enables and the soft reset pulse come from registers outside this slice
// on the same clock, so they are used without synchronisers.
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module svc_config_regs (
  // Clock, reset and enable
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic clk_en_in,
  // Register port
  input wire logic [7:0] addr_in,
  input wire logic [15:0] wr_data_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  output logic [15:0] rd_data_out,
  // Bits held outside this slice
  input wire logic soft_reset_in,
  input wire logic osc_bias_override_enable_in,
  input wire logic osc_band_override_enable_in,
  // Calibration results
  input wire logic [8:0] cal_bias_in,
  input wire logic [7:0] cal_band_in,
  input wire logic [2:0] cal_core_in,
  // Settings applied to the analog core
  output logic [3:0] pump_gain_code_out,
  output logic pump_tristate_out,
  output logic [8:0] osc_bias_cal_start_out,
  output logic [8:0] osc_bias_applied_out,
  output logic [7:0] osc_band_applied_out,
  output logic [2:0] core_applied_out
);
  // ****************************************************************
  // Address decode
  // ****************************************************************
  // Offset relative to the slice, hit flag and array index of the current request.
  logic [7:0] rel_addr;
  logic hit;
  logic [2:0] idx;

  // One subtraction yields both the range test and the array index.
  // Offsets below the base wrap high and fall outside the slice.
  always_comb begin
    rel_addr = addr_in - svc_pkg::SLICE_BASE_OFS;
    hit = (rel_addr < 8'(svc_pkg::NUM_REGS));
    idx = rel_addr[2:0];
  end

  // ****************************************************************
  // Register array
  // ****************************************************************
  // One entry per offset, index 0 at the lowest offset.
  logic [15:0] regs_q [svc_pkg::NUM_REGS];
  logic [15:0] regs_d [svc_pkg::NUM_REGS];

  // Per entry: a write wins over a coincident soft reset, so no host data is lost.
  genvar gi;
  generate
    for (gi = 0; gi < svc_pkg::NUM_REGS; gi++) begin : g_reg
      always_comb begin
        regs_d[gi] = regs_q[gi];
        if (clk_en_in && wr_en_in && hit && idx == 3'(gi)) begin
          regs_d[gi] = wr_data_in;
        end else if (clk_en_in && soft_reset_in) begin
          regs_d[gi] = svc_pkg::RESET_TABLE[gi*16 +: 16];
        end
      end
    end
  endgenerate

  // The reset table holds the eight reset words with the lowest offset in the low bits.
  // Reserved patterns are stored as written; nothing masks them.
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      for (int i = 0; i < svc_pkg::NUM_REGS; i++) begin
        regs_q[i] <= svc_pkg::RESET_TABLE[i*16 +: 16];
      end
    end else begin
      for (int i = 0; i < svc_pkg::NUM_REGS; i++) begin
        regs_q[i] <= regs_d[i];
      end
    end
  end

  // ****************************************************************
  // Readback
  // ****************************************************************
  // Next and registered read data.
  logic [15:0] rd_data_d;
  logic [15:0] rd_data_q;

  // While the enable is low the answer is held, so a stalled host still finds it.
  // Data stands only in the cycle after the strobe; unmapped offsets read zero.
  always_comb begin
    rd_data_d = 16'h0000;
    if (!clk_en_in) begin
      rd_data_d = rd_data_q;
    end else if (rd_en_in && hit) begin
      rd_data_d = regs_q[idx];
    end
  end

  // Read data register; reset clears it so the port idles at zero.
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rd_data_q <= 16'h0000;
    end else begin
      rd_data_q <= rd_data_d;
    end
  end

  assign rd_data_out = rd_data_q;

  // ****************************************************************
  // Override selection
  // ****************************************************************
  svc_ovr_if ovr ();

  // Override bits from the other register group and from register 20 steer the mux.
  always_comb begin
    ovr.bias_cal = cal_bias_in;
    ovr.bias_man = regs_q[svc_pkg::IDX_BIAS][svc_pkg::BIAS_W-1:0];
    ovr.bias_force = osc_bias_override_enable_in;
    ovr.band_cal = cal_band_in;
    ovr.band_man = regs_q[svc_pkg::IDX_BAND][svc_pkg::BAND_W-1:0];
    ovr.band_force = osc_band_override_enable_in;
    ovr.core_cal = cal_core_in;
    ovr.core_man = regs_q[svc_pkg::IDX_CORE][svc_pkg::CORE_SEL_LSB +: svc_pkg::CORE_SEL_W];
    ovr.core_force = regs_q[svc_pkg::IDX_CORE][svc_pkg::CORE_OVR_BIT];
  end

  // The selector is purely combinational; its results are registered below.
  svc_override_mux u_mux (
    .ovr(ovr.sel)
  );

  // ****************************************************************
  // Applied settings
  // ****************************************************************
  // Next and registered copies of each setting driven toward the analog core.
  logic [3:0] gain_d;
  logic [3:0] gain_q;
  logic tri_d;
  logic tri_q;
  logic [8:0] start_d;
  logic [8:0] start_q;
  logic [8:0] bias_d;
  logic [8:0] bias_q;
  logic [7:0] band_d;
  logic [7:0] band_q;
  logic [2:0] core_d;
  logic [2:0] core_q;

  // Outputs are registered so the analog side sees glitch-free codes, one cycle late.
  always_comb begin
    gain_d = gain_q;
    tri_d = tri_q;
    start_d = start_q;
    bias_d = bias_q;
    band_d = band_q;
    core_d = core_q;
    // Every setting holds its value while the enable is low.
    if (clk_en_in) begin
      gain_d = regs_q[svc_pkg::IDX_PUMP][svc_pkg::PUMP_GAIN_LSB +: svc_pkg::PUMP_GAIN_W];
      tri_d = (gain_d == svc_pkg::PUMP_GAIN_TRISTATE);
      start_d = regs_q[svc_pkg::IDX_START][svc_pkg::BIAS_W-1:0];
      bias_d = ovr.bias_sel;
      // Codes above the top band are out of range; clamp rather than pass them on.
      band_d = (ovr.band_sel > svc_pkg::BAND_CODE_MAX) ? svc_pkg::BAND_CODE_MAX
                                                      : ovr.band_sel;
      core_d = ovr.core_sel;
    end
  end

  // Gain and start follow their registers from reset; the selected values start at zero.
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      gain_q <= svc_pkg::PUMP_GAIN_CONTROL_RST[svc_pkg::PUMP_GAIN_LSB +: svc_pkg::PUMP_GAIN_W];
      tri_q <= 1'b0;
      start_q <= svc_pkg::OSC_CURRENT_CAL_START_RST[svc_pkg::BIAS_W-1:0];
      bias_q <= 9'h000;
      band_q <= 8'h00;
      core_q <= 3'h0;
    end else begin
      gain_q <= gain_d;
      tri_q <= tri_d;
      start_q <= start_d;
      bias_q <= bias_d;
      band_q <= band_d;
      core_q <= core_d;
    end
  end

  // The ports come straight from the flops.
  assign pump_gain_code_out = gain_q;
  assign pump_tristate_out = tri_q;
  assign osc_bias_cal_start_out = start_q;
  assign osc_bias_applied_out = bias_q;
  assign osc_band_applied_out = band_q;
  assign core_applied_out = core_q;
endmodule
`default_nettype wire

// ### testbench/svc_config_regs_asserts.sv
// Port-level assertion checker for the configuration slice.
`timescale 1ns/1ps
`default_nettype none
module svc_config_regs_chk (
  // Clock, reset and control
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic clk_en_in,
  input wire logic soft_reset_in,
  // Register port
  input wire logic [7:0] addr_in,
  input wire logic [15:0] wr_data_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  input wire logic [15:0] rd_data_out,
  // Override inputs
  input wire logic osc_bias_override_enable_in,
  input wire logic osc_band_override_enable_in,
  input wire logic [8:0] cal_bias_in,
  input wire logic [7:0] cal_band_in,
  input wire logic [2:0] cal_core_in,
  // Applied settings
  input wire logic [3:0] pump_gain_code_out,
  input wire logic pump_tristate_out,
  input wire logic [8:0] osc_bias_cal_start_out,
  input wire logic [8:0] osc_bias_applied_out,
  input wire logic [7:0] osc_band_applied_out,
  input wire logic [2:0] core_applied_out
);
  // One clock domain, so clocking and disable are shared.
  default clocking cb @(posedge clock_in); endclocking
  // The design is still cleared at the edge that releases reset, so checks stay off there
  // too; otherwise $past would hold live inputs against outputs still at reset values.
  logic rst_tail_q;
  default disable iff (sys_rst_in || rst_tail_q);

  // High during reset and for the one edge that ends it.
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rst_tail_q <= 1'b1;
    end else begin
      rst_tail_q <= 1'b0;
    end
  end

  // Read data stands one cycle only; a stuck value would fool software.
  rd_idle_zero_a:
    assert property ($past(clk_en_in) && !$past(rd_en_in) |-> rd_data_out == 16'h0000)
    else $error("read data not zero outside answer");
  rd_unmapped_a:
    assert property (rd_en_in && clk_en_in && (addr_in < 8'h0d || addr_in > 8'h14)
      |=> rd_data_out == 16'h0000) else $error("unmapped read not zero");
  gain_tristate_a:
    assert property (pump_tristate_out == (pump_gain_code_out == 4'h0))
    else $error("tristate does not match gain code");
  gain_write_a:
    assert property (wr_en_in && clk_en_in && addr_in == 8'h0e ##1 clk_en_in && !soft_reset_in
      && !wr_en_in |=> pump_gain_code_out == $past(wr_data_in[6:3], 2))
    else $error("gain code not taken from write");
  gain_readback_a:
    assert property (rd_en_in && clk_en_in && addr_in == 8'h0e
      |=> rd_data_out[6:3] == pump_gain_code_out) else $error("gain readback differs");
  start_readback_a:
    assert property (rd_en_in && clk_en_in && addr_in == 8'h11
      |=> rd_data_out[8:0] == osc_bias_cal_start_out) else $error("start readback differs");
  bias_cal_path_a:
    assert property (clk_en_in && !osc_bias_override_enable_in
      |=> osc_bias_applied_out == $past(cal_bias_in)) else $error("bias not from calibration");
  band_cal_path_a:
    assert property (clk_en_in && !osc_band_override_enable_in && cal_band_in <= 8'hb7
      |=> osc_band_applied_out == $past(cal_band_in)) else $error("band not from calibration");
  band_limit_a:
    assert property (clk_en_in && osc_band_override_enable_in |=> osc_band_applied_out <= 8'hb7)
    else $error("band above limit");
  core_legal_a:
    assert property (clk_en_in |=> core_applied_out == $past(cal_core_in)
      || core_applied_out inside {[3'h1:3'h6]}) else $error("core code illegal");
  soft_gain_a:
    assert property (soft_reset_in && clk_en_in && !wr_en_in ##1 clk_en_in && !wr_en_in
      |=> pump_gain_code_out == 4'h8) else $error("gain not restored by soft reset");
endmodule

bind svc_config_regs svc_config_regs_chk u_chk (
  .clock_in(clock_in), .sys_rst_in(sys_rst_in), .clk_en_in(clk_en_in),
  .soft_reset_in(soft_reset_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
  .wr_en_in(wr_en_in), .rd_en_in(rd_en_in), .rd_data_out(rd_data_out),
  .osc_bias_override_enable_in(osc_bias_override_enable_in),
  .osc_band_override_enable_in(osc_band_override_enable_in),
  .cal_bias_in(cal_bias_in), .cal_band_in(cal_band_in), .cal_core_in(cal_core_in),
  .pump_gain_code_out(pump_gain_code_out), .pump_tristate_out(pump_tristate_out),
  .osc_bias_cal_start_out(osc_bias_cal_start_out), .osc_bias_applied_out(osc_bias_applied_out),
  .osc_band_applied_out(osc_band_applied_out), .core_applied_out(core_applied_out)
);
`default_nettype wire

// ### testbench/svc_host_model.sv
// Host model that issues register writes and reads toward the slice.
`timescale 1ns/1ps
`default_nettype none
module svc_host_model (
  // Clock
  input wire logic clock_in,
  // Register port toward the device
  output logic [7:0] addr_out,
  output logic [15:0] wr_data_out,
  output logic wr_en_out,
  output logic rd_en_out,
  input wire logic [15:0] rd_data_in
);
  // Idle bus at time zero.
  initial begin
    addr_out = 8'hff;
    wr_data_out = 16'hffff;
    wr_en_out = 1'b0;
    rd_en_out = 1'b0;
  end

  // One write cycle; address and data are inverted after, so stale values are never trusted.
  task automatic write(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock_in);
    addr_out <= a;
    wr_data_out <= d;
    wr_en_out <= 1'b1;
    @(posedge clock_in);
    wr_en_out <= 1'b0;
    addr_out <= ~a;
    wr_data_out <= ~d;
  endtask

  // One read cycle; the answer is taken in the single cycle after the strobe.
  task automatic read(input logic [7:0] a, output logic [15:0] d);
    @(posedge clock_in);
    addr_out <= a;
    rd_en_out <= 1'b1;
    @(posedge clock_in);
    rd_en_out <= 1'b0;
    addr_out <= ~a;
    #1 d = rd_data_in;
  endtask
endmodule
`default_nettype wire

// ### testbench/tb_top.sv
// Self-checking testbench for the configuration slice.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clock_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic clk_en_in = 1'b1;
  logic soft_reset_in = 1'b0;
  logic bias_en = 1'b0;
  logic band_en = 1'b0;
  logic [8:0] cal_bias = 9'h055;
  logic [7:0] cal_band = 8'h40;
  logic [2:0] cal_core = 3'h2;
  logic [7:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic [15:0] got;
  logic wr;
  logic rd;
  logic [3:0] gain;
  logic tri_o;
  logic [8:0] start;
  logic [8:0] bias;
  logic [7:0] band;
  logic [2:0] core;
  int bad_count = 0;
  int total_checks = 0;
  logic [15:0] rst_val [8] = '{16'h4000, 16'h1840, 16'h060e, 16'h0080,
    16'h0096, 16'h0064, 16'h27b7, 16'h3048};

  // Free-running 250 MHz clock.
  always #2 clock_in = ~clock_in;

  svc_host_model host (.clock_in(clock_in), .addr_out(addr), .wr_data_out(wdata),
    .wr_en_out(wr), .rd_en_out(rd), .rd_data_in(rdata));

  svc_config_regs dut (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .clk_en_in(clk_en_in),
    .addr_in(addr), .wr_data_in(wdata), .wr_en_in(wr), .rd_en_in(rd), .rd_data_out(rdata),
    .soft_reset_in(soft_reset_in), .osc_bias_override_enable_in(bias_en),
    .osc_band_override_enable_in(band_en), .cal_bias_in(cal_bias), .cal_band_in(cal_band),
    .cal_core_in(cal_core), .pump_gain_code_out(gain), .pump_tristate_out(tri_o),
    .osc_bias_cal_start_out(start), .osc_bias_applied_out(bias),
    .osc_band_applied_out(band), .core_applied_out(core));

  // Compare one value and count it.
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Applied outputs trail a write by two edges; three leaves margin.
  task automatic settle();
    repeat (3) @(posedge clock_in);
    #1;
  endtask

  // Read every register and compare against the table.
  task automatic read_all(input logic inv);
    for (int i = 0; i < 8; i++) begin
      host.read(8'h0d + 8'(i), got);
      chk(got, inv ? ~rst_val[i] : rst_val[i]);
    end
  endtask

  task automatic t_reset();
    host.write(8'h0d, 16'h4000);
    host.write(8'h0f, 16'h060e);
    host.write(8'h12, 16'h0064);
    read_all(1'b0);
    chk({12'h000, gain}, 16'h0008);
    chk({7'h00, start}, 16'h0096);
    $display("Test reset values done");
  endtask

  // Every gain code, including the tri-state code.
  task automatic t_gain();
    for (int g = 0; g < 16; g++) begin
      host.write(8'h0e, {9'h030, 4'(g), 3'h0});
      settle();
      chk({12'h000, gain}, 16'(g));
      chk({15'h0000, tri_o}, {15'h0000, g == 0});
    end
    $display("Test pump gain done");
  endtask

  task automatic t_override();
    chk({7'h00, bias}, 16'h0055);
    chk({8'h00, band}, 16'h0040);
    chk({13'h0000, core}, 16'h0002);
    host.write(8'h10, 16'h0123);
    host.write(8'h13, 16'h27a0);
    host.write(8'h14, 16'h1c48);
    @(posedge clock_in);
    bias_en <= 1'b1;
    band_en <= 1'b1;
    settle();
    chk({7'h00, bias}, 16'h0123);
    chk({8'h00, band}, 16'h00a0);
    chk({13'h0000, core}, 16'h0003);
    host.write(8'h14, 16'h3c48);
    host.write(8'h13, 16'h27c8);
    settle();
    chk({13'h0000, core}, 16'h0002);
    chk({8'h00, band}, 16'h00b7);
    $display("Test overrides done");
  endtask

  // Full-width storage, unmapped places, then a software reset.
  task automatic t_rw_soft();
    for (int i = 0; i < 8; i++) host.write(8'h0d + 8'(i), ~rst_val[i]);
    host.write(8'h15, 16'h1234);
    read_all(1'b1);
    host.read(8'h0c, got);
    chk(got, 16'h0000);
    host.read(8'h15, got);
    chk(got, 16'h0000);
    @(posedge clock_in);
    soft_reset_in <= 1'b1;
    @(posedge clock_in);
    soft_reset_in <= 1'b0;
    read_all(1'b0);
    chk({12'h000, gain}, 16'h0008);
    $display("Test storage and soft reset done");
  endtask

  // A write while the clock enable is low must leave register and gain untouched.
  task automatic t_enable();
    @(posedge clock_in);
    clk_en_in <= 1'b0;
    host.write(8'h0e, 16'h1800);
    clk_en_in <= 1'b1;
    settle();
    chk({12'h000, gain}, 16'h0008);
    host.read(8'h0e, got);
    chk(got, 16'h1840);
    $display("Test clock enable done");
  endtask

  // Print counts and the verdict, then stop.
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Watchdog well beyond the two hundred or so cycles the tests need.
  initial begin
    #40000;
    bad_count++;
    tally_and_finish();
  end

  // Main sequence.
  initial begin
    repeat (10) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    t_reset();
    t_gain();
    t_override();
    t_rw_soft();
    t_enable();
    tally_and_finish();
  end
endmodule
`default_nettype wire
